// ---- uart_status_and_clock_select_tb.sv ----
`timescale 1ns/1ps
`include "usc_regs.svh"
// Self-checking bench for status and clock select
module uart_status_and_clock_select_tb
   import usc_pkg::*;
;
   // Transmit buffer address on the bus
   localparam logic [15:0] TX_BUF = 16'hFF54;
   typedef struct packed {
      usc_par_t   mode;  // Parity mode
      logic [7:0] data;  // Received character
      logic       par;   // Received parity bit
      logic       stop;  // First stop bit
      logic [7:0] exp;   // Expected error status
   } usc_row_t;
   usc_row_t rows[7] = '{
      '{USC_PAR_NONE, 8'h01, 1'b1, 1'b1, 8'h00}, '{USC_PAR_ZERO, 8'h01, 1'b1, 1'b1, 8'h00},
      '{USC_PAR_ODD, 8'h01, 1'b1, 1'b1, 8'h04}, '{USC_PAR_ODD, 8'h01, 1'b0, 1'b1, 8'h00},
      '{USC_PAR_EVEN, 8'h03, 1'b1, 1'b1, 8'h04}, '{USC_PAR_EVEN, 8'h03, 1'b0, 1'b0, 8'h02},
      '{USC_PAR_ODD, 8'h00, 1'b1, 1'b0, 8'h02}};
   logic         ref_clk = 1'b0;
   logic         rst_n = 1'b0;
   usc_bus_t     bus = '0;
   logic [7:0]   rdata;
   logic         busWait;
   logic         interfacePowerBit = 1'b1;
   logic         transmitEnableBit = 1'b1;
   logic         receiveEnableBit = 1'b1;
   usc_par_t     parityMode = USC_PAR_NONE;
   logic         rxDoneValid;
   usc_rx_done_t rxDone;
   logic         rxBufRead = 1'b0;
   logic [7:0]   receiveBuffer;
   logic         rxBufValid;
   logic         timerOut = 1'b0;
   logic         baseClockEn;
   logic [7:0]   txShiftData;
   logic         txShiftLoad;
   logic         txFrameDone;
   logic         fifoInReady;
   logic         stall = 1'b1;
   logic         sendReq = 1'b0;
   usc_rx_done_t sendChar = '0;
   logic         lastWait;
   int           cnt;
   int           mismatches = 0;
   int           cmp_count = 0;
   usc_status i_dut (.ref_clk, .rst_n, .bus, .rdata, .busWait, .interfacePowerBit, .transmitEnableBit,
      .receiveEnableBit, .parityMode, .rxDoneValid, .rxDone, .rxBufRead, .receiveBuffer, .rxBufValid,
      .timerOut, .baseClockEn, .txShiftData, .txShiftLoad, .txFrameDone, .fifoInReady);
   usc_node_model i_node (.ref_clk, .rst_n, .stall, .txShiftLoad, .txShiftData, .txFrameDone,
      .sendReq, .sendChar, .rxDoneValid, .rxDone);
   // Clock, 25 ns period
   always #12.5 ref_clk = ~ref_clk;
   // timer already running
   // Timer output toggles every 8 cycles
   always begin
      repeat (8) @(negedge ref_clk);
      timerOut = ~timerOut;
   end
   // Compare and count
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One bus write
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
      @(negedge ref_clk);
      bus.wr = 1'b0;
   endtask
   // One bus read, checked against e
   task automatic rdChk(input logic [15:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      bus.rd = 1'b1;
      bus.addr = a;
      @(negedge ref_clk);
      bus.rd = 1'b0;
      lastWait = busWait;
      check($sformatf("reg %h", a), 16'(rdata), 16'(e));
      @(negedge ref_clk);
   endtask
   // Remote node completes one character
   task automatic send(input logic [7:0] d, input logic p, input logic s);
      @(negedge ref_clk);
      sendReq = 1'b1;
      sendChar = '{data: d, parityBit: p, firstStop: s};
      @(negedge ref_clk);
      sendReq = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask
   // CPU reads the receive buffer
   task automatic bufRd();
      @(negedge ref_clk);
      rxBufRead = 1'b1;
      @(negedge ref_clk);
      rxBufRead = 1'b0;
   endtask
   // Cycles between base clock pulses
   task automatic period(output int n);
      n = 0;
      for (int k = 0; k < 2100 && !baseClockEn; k++) begin
         @(negedge ref_clk);
      end
      do begin
         @(negedge ref_clk);
         n++;
      end while (!baseClockEn && n < 2100);
   endtask
   // Verdict and end of run
   task automatic close_out();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Watchdog
   initial begin
      #500000;
      mismatches++;
      close_out();
   end
   // Main sequence
   initial begin
      repeat (2) @(negedge ref_clk);
      rst_n = 1'b1;
      rdChk(`USC_ADDR_RX_ERR, 8'h00);
      rdChk(`USC_ADDR_TX_STAT, 8'h00);
      rdChk(`USC_ADDR_CLK_SEL, 8'h00);
      // Error flag table
      foreach (rows[i]) begin
         parityMode = rows[i].mode;
         send(rows[i].data, rows[i].par, rows[i].stop);
         rdChk(`USC_ADDR_RX_ERR, rows[i].exp);
         check("busWait", 16'(lastWait), 16'h0001);
         check("receiveBuffer", 16'(receiveBuffer), 16'(rows[i].data));
         bufRd();
         rdChk(`USC_ADDR_RX_ERR, 8'h00);
      end
      // Overrun keeps the older character
      parityMode = USC_PAR_NONE;
      send(8'hA5, 1'b0, 1'b1);
      send(8'h5A, 1'b0, 1'b1);
      rdChk(`USC_ADDR_RX_ERR, 8'h01);
      check("receiveBuffer", 16'(receiveBuffer), 16'h00A5);
      bufRd();
      // Receive disable, then power off, clear flags
      for (int k = 0; k < 2; k++) begin
         send(8'h11, 1'b0, 1'b0);
         receiveEnableBit = (k != 0);
         interfacePowerBit = (k == 0);
         @(negedge ref_clk);
         {interfacePowerBit, receiveEnableBit} = 2'b11;
         rdChk(`USC_ADDR_RX_ERR, 8'h00);
         bufRd();
      end
      // Fill the transmit path while the shifter stalls
      wr(TX_BUF, 8'h10);
      rdChk(`USC_ADDR_TX_STAT, 8'h01);
      for (int k = 1; k < 17; k++) begin
         wr(TX_BUF, 8'h10 + k[7:0]);
      end
      check("fifoInReady", 16'(fifoInReady), 16'h0000);
      wr(TX_BUF, 8'hEE);
      rdChk(`USC_ADDR_TX_STAT, 8'h03);
      stall = 1'b0;
      repeat (340) @(negedge ref_clk);
      rdChk(`USC_ADDR_TX_STAT, 8'h00);
      check("loads", 16'(i_node.loaded.size()), 16'd17);
      foreach (i_node.loaded[k]) begin
         check("txShiftData", 16'(i_node.loaded[k]), 16'(8'h10 + k[7:0]));
      end
      check("gap", 16'(i_node.maxGap <= 4), 16'h0001);
      wr(`USC_ADDR_TX_STAT, 8'hFF);
      rdChk(`USC_ADDR_TX_STAT, 8'h00);
      // Transmit disable clears pending status
      stall = 1'b1;
      wr(TX_BUF, 8'h21);
      wr(TX_BUF, 8'h22);
      transmitEnableBit = 1'b0;
      @(negedge ref_clk);
      transmitEnableBit = 1'b1;
      rdChk(`USC_ADDR_TX_STAT, 8'h00);
      // Divider codes, refreshed while powered
      for (int n = 0; n < 11; n++) begin
         interfacePowerBit = 1'b0;
         wr(`USC_ADDR_CLK_SEL, 8'hF0 | n[7:0]);
         interfacePowerBit = 1'b1;
         rdChk(`USC_ADDR_CLK_SEL, n[7:0]);
         wr(`USC_ADDR_CLK_SEL, n[7:0]);
         period(cnt);
         check("period", 16'(cnt), 16'(1 << n));
      end
      wr(16'hFF57, 8'h05);
      rdChk(`USC_ADDR_CLK_SEL, 8'h0A);
      // Timer code gives pulses, reserved code none
      for (int n = 11; n < 13; n++) begin
         interfacePowerBit = 1'b0;
         wr(`USC_ADDR_CLK_SEL, n[7:0]);
         interfacePowerBit = 1'b1;
         cnt = 0;
         repeat (64) begin
            @(negedge ref_clk);
            cnt += int'(baseClockEn);
         end
         check("pulses", 16'(cnt > 0), 16'(n == 11));
      end
      close_out();
   end
endmodule

// ---- usc_fifo.sv ----
`timescale 1ns/1ps
// Synchronous FIFO with valid/ready on both sides
module usc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             flush,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);
   localparam int AW = $clog2(DEPTH);
   // Storage
   logic [WIDTH-1:0] mem [DEPTH];
   // Pointers and fill level
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } usc_fifo_st_t;
   usc_fifo_st_t st;
   usc_fifo_st_t next_st;
   logic push;
   logic pop;
   assign inReady  = (st.cnt != (AW+1)'(DEPTH));
   assign outValid = (st.cnt != '0);
   assign outData  = mem[st.rp];
   assign push     = inValid && inReady;
   assign pop      = outValid && outReady;
   // Next pointers
   always_comb begin
      next_st = st;
      if (push) begin
         next_st.wp = st.wp + 1'b1;
      end
      if (pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         next_st = '0;
      end
   end
   // Register pointers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   // Storage write
   always_ff @(posedge clk) begin
      if (push) begin
         mem[st.wp] <= inData;
      end
   end
endmodule

// ---- usc_node_model.sv ----
`timescale 1ns/1ps
// Shift stage and remote node behind the status block
module usc_node_model
   import usc_pkg::*;
#(
   parameter int FRAME = 6  // Cycles per frame
) (
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire logic         stall,
   input  wire logic         txShiftLoad,
   input  wire logic [7:0]   txShiftData,
   output logic              txFrameDone,
   input  wire logic         sendReq,
   input  wire usc_rx_done_t sendChar,
   output logic              rxDoneValid,
   output usc_rx_done_t      rxDone
);
   logic [7:0] loaded[$];     // Bytes taken into the shifter
   int         left   = 0;    // Cycles left in the frame
   int         gap    = 0;    // Cycles since a frame ended
   int         maxGap = 0;    // Longest frame end to next load
   logic       pend   = 1'b0; // Frame ended, next load awaited
   initial begin
      txFrameDone = 1'b0;
      rxDoneValid = 1'b0;
      rxDone      = '0;
   end
   // Frame timing, receive completions
   always @(posedge ref_clk) begin
      rxDoneValid <= sendReq;
      // Idle lines toggle so a stale value never passes
      rxDone      <= sendReq ? sendChar : ~rxDone;
      txFrameDone <= 1'b0;
      gap         <= gap + 1;
      if (!rst_n) begin
         left <= 0;
         pend <= 1'b0;
      end else if (txShiftLoad) begin
         loaded.push_back(txShiftData);
         left <= FRAME;
         pend <= 1'b0;
         if (pend && gap > maxGap) begin
            maxGap <= gap;
         end
      end else if (left > 0 && !stall) begin
         // Frame end is held off while stalled
         left <= left - 1;
         if (left == 1) begin
            txFrameDone <= 1'b1;
            pend        <= 1'b1;
            gap         <= 0;
         end
      end
   end
endmodule

// ---- usc_pkg.sv ----
package usc_pkg;
   // Parity mode field of the operation mode register
   typedef enum logic [1:0] {
      USC_PAR_NONE = 2'b00,
      USC_PAR_ZERO = 2'b01,
      USC_PAR_ODD  = 2'b10,
      USC_PAR_EVEN = 2'b11
   } usc_par_t;
   // Reception completion event from the receive shifter
   typedef struct packed {
      logic [7:0] data;
      logic       parityBit;
      logic       firstStop;
   } usc_rx_done_t;
   // CPU bus request
   typedef struct packed {
      logic        rd;
      logic        wr;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } usc_bus_t;
   // Transmit state machine
   typedef enum logic [2:0] {
      USC_TX_IDLE  = 3'b001,
      USC_TX_LOAD  = 3'b010,
      USC_TX_SHIFT = 3'b100
   } usc_tx_st_t;
endpackage

// ---- usc_regs.svh ----
`ifndef USC_REGS_SVH
`define USC_REGS_SVH
// Register addresses on the CPU memory bus
`define USC_ADDR_RX_ERR      16'hFF53
`define USC_ADDR_TX_STAT     16'hFF55
`define USC_ADDR_CLK_SEL     16'hFF56
// Reset values
`define USC_RST_RX_ERR       8'h00
`define USC_RST_TX_STAT      8'h00
`define USC_RST_CLK_SEL      4'h0
// Receive error status field positions
`define USC_BIT_PARITY_ERR   2
`define USC_BIT_FRAMING_ERR  1
`define USC_BIT_OVERRUN_ERR  0
// Transmit status field positions
`define USC_BIT_TX_BUF_FULL  1
`define USC_BIT_TX_SHIFT     0
// Clock select codes
`define USC_SEL_MAX_DIV      4'hA
`define USC_SEL_TIMER        4'hB
`define USC_DIV_BITS         10
// Read wait cycles inserted on a receive error status read
`define USC_READ_WAIT        1
// Data FIFO depth
`define USC_FIFO_DEPTH       16
`endif

// ---- usc_status.sv ----
`timescale 1ns/1ps
//
// What this block does
// - Error status clears on reset, power, rxEnable
// - Reading error status clears its flags
// - Parity mismatch at completion sets bit 2
// - Missing stop bit sets framing bit 1
// - Completion with unread buffer sets overrun
// - Only first stop bit is checked
// - Overrun discards new character, keeps buffer
// - Parity checked only in odd/even modes
// - Error status read inserts one wait
// - Buffer flag: set on write, clear on move of last byte
// - Shift flag: set on move, clear at end
// - Transmit status clears on reset, power, txEnable
// - Next byte after move keeps gap-free
// - Codes 0 to 10 select divide by 2^n
// - Clock select resets zero, accepts refresh
// - Unused high bits read as zero
// - Power off stops clock, clears status
// - Zero parity mode never sets parity flag
//
module usc_status
   import usc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   input  wire usc_bus_t     bus,
   output logic [7:0]        rdata,
   output logic              busWait,
   input  wire logic         interfacePowerBit,
   input  wire logic         transmitEnableBit,
   input  wire logic         receiveEnableBit,
   input  wire usc_par_t     parityMode,
   input  wire logic         rxDoneValid,
   input  wire usc_rx_done_t rxDone,
   input  wire logic         rxBufRead,
   output logic [7:0]        receiveBuffer,
   output logic              rxBufValid,
   input  wire logic         timerOut,
   output logic              baseClockEn,
   output logic [7:0]        txShiftData,
   output logic              txShiftLoad,
   input  wire logic         txFrameDone,
   output logic              fifoInReady
);
`include "usc_regs.svh"
   // All block state except the FIFO
   typedef struct packed {
      logic [2:0]             rxErr;       // Parity, framing, overrun
      logic [7:0]             rxBuf;       // Receive buffer
      logic                   rxFull;      // Unread character held
      logic                   txBufFull;   // Buffer flag
      logic                   txShiftBusy; // Shift flag
      logic [3:0]             clkSel;      // Base clock select
      logic [`USC_DIV_BITS:0] prescale;    // Prescaler taps
      logic                   timerSync1;  // Timer output sync stage 1
      logic                   timerSync2;  // Timer output sync stage 2
      logic                   timerPrev;   // Edge detect of timer
      logic                   baseEn;      // Base clock enable pulse
      logic [7:0]             rdata;       // Read data
      logic                   waitQ;       // Wait state
      logic                   rdPend;      // Error status read pending
      logic [7:0]             txData;      // Data to shifter
      logic                   txLoad;      // Load pulse
      usc_tx_st_t             txSt;        // Transmit sequencer
   } usc_st_t;
   usc_st_t st;
   usc_st_t next_st;
   // FIFO links
   logic [7:0] fifoOutData;
   logic       fifoOutValid;
   logic       fifoOutReady;
   logic       fifoPush;
   logic       txOn;
   logic       rxOn;
   logic       errRead;
   logic       parityBad;
   logic       tapEn;
   assign txOn     = interfacePowerBit && transmitEnableBit;
   assign rxOn     = interfacePowerBit && receiveEnableBit;
   assign fifoPush = bus.wr && (bus.addr == `USC_ADDR_TX_STAT - 16'h0001) && txOn;
   // Data buffer in the transmit path
   usc_fifo #(
      .WIDTH (8),
      .DEPTH (`USC_FIFO_DEPTH)
   ) u_fifo (
      .clk      (ref_clk),
      .rst_n    (rst_n),
      .flush    (!txOn),
      .inData   (bus.wdata),
      .inValid  (fifoPush),
      .inReady  (fifoInReady),
      .outData  (fifoOutData),
      .outValid (fifoOutValid),
      .outReady (fifoOutReady)
   );
   // Shift register takes a word when not in SHIFT (idle or load) or a frame ends
   assign fifoOutReady = (st.txSt != USC_TX_SHIFT) || txFrameDone;
   // Parity check of received character
   always_comb begin
      parityBad = 1'b0;
      unique case (parityMode)
         USC_PAR_NONE: parityBad = 1'b0;
         USC_PAR_ZERO: parityBad = 1'b0;
         USC_PAR_ODD:  parityBad = ~^{rxDone.data, rxDone.parityBit};
         USC_PAR_EVEN: parityBad = ^{rxDone.data, rxDone.parityBit};
      endcase
   end
   // Base clock tap select
   always_comb begin
      tapEn = 1'b0;
      if (st.clkSel <= `USC_SEL_MAX_DIV) begin
         // divide by two to the n
         tapEn = (st.prescale & ((`USC_DIV_BITS+1)'(1) << st.clkSel) - 1'b1) == '0;
      end else if (st.clkSel == `USC_SEL_TIMER) begin
         tapEn = st.timerSync2 && !st.timerPrev;
      end
   end
   assign errRead = bus.rd && (bus.addr == `USC_ADDR_RX_ERR);
   // Next state
   always_comb begin
      next_st = st;
      next_st.txLoad     = 1'b0;
      next_st.timerSync1 = timerOut;
      next_st.timerSync2 = st.timerSync1;
      next_st.timerPrev  = st.timerSync2;
      next_st.prescale   = interfacePowerBit ? st.prescale + 1'b1 : '0;
      next_st.baseEn     = interfacePowerBit && tapEn;
      // Read path
      next_st.rdata = 8'h00;
      // one wait cycle on error read
      next_st.waitQ  = errRead && !st.waitQ;
      next_st.rdPend = errRead && !st.waitQ;
      if (bus.rd) begin
         unique case (bus.addr)
            `USC_ADDR_RX_ERR:  next_st.rdata = {5'h00, st.rxErr};
            `USC_ADDR_TX_STAT: next_st.rdata = {6'h00, st.txBufFull, st.txShiftBusy};
            `USC_ADDR_CLK_SEL: next_st.rdata = {4'h0, st.clkSel};
            default:           next_st.rdata = 8'h00;
         endcase
      end
      if (st.rdPend) begin
         next_st.rxErr = 3'b000;
      end
      // Receive buffer read
      if (rxBufRead) begin
         next_st.rxFull = 1'b0;
      end
      // Reception completion, set beats clear
      if (rxDoneValid && rxOn) begin
         if (parityBad) begin
            next_st.rxErr[`USC_BIT_PARITY_ERR] = 1'b1;
         end
         if (!rxDone.firstStop) begin
            next_st.rxErr[`USC_BIT_FRAMING_ERR] = 1'b1;
         end
         if (st.rxFull && !rxBufRead) begin
            next_st.rxErr[`USC_BIT_OVERRUN_ERR] = 1'b1;
         end else begin
            next_st.rxBuf  = rxDone.data;
            next_st.rxFull = 1'b1;
         end
      end
      if (bus.wr && bus.addr == `USC_ADDR_CLK_SEL) begin
         next_st.clkSel = bus.wdata[3:0];
      end
      // Transmit sequencer
      unique case (st.txSt)
         USC_TX_IDLE: begin
            if (fifoOutValid) begin
               next_st.txSt = USC_TX_LOAD;
            end
         end
         USC_TX_LOAD: begin
            next_st.txSt = USC_TX_SHIFT;
         end
         USC_TX_SHIFT: begin
            if (txFrameDone && !fifoOutValid) begin
               next_st.txSt = USC_TX_IDLE;
            end
         end
      endcase
      if (fifoPush) begin
         next_st.txBufFull = 1'b1;
      end
      if (fifoOutValid && fifoOutReady) begin
         next_st.txData      = fifoOutData;
         next_st.txLoad      = 1'b1;
         next_st.txShiftBusy = 1'b1;
         // clear when moved and nothing more
         next_st.txBufFull   = fifoPush || (u_fifo.st.cnt > 5'd1);
      end else if (txFrameDone && st.txSt == USC_TX_SHIFT) begin
         // clear at end with nothing queued
         next_st.txShiftBusy = 1'b0;
      end
      if (!rxOn) begin
         next_st.rxErr  = 3'b000;
         next_st.rxFull = 1'b0;
      end
      if (!txOn) begin
         next_st.txBufFull   = 1'b0;
         next_st.txShiftBusy = 1'b0;
         next_st.txSt        = USC_TX_IDLE;
         next_st.txLoad      = 1'b0;
      end
   end
   // State register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         st        <= '0;
         st.rxBuf  <= 8'hFF;
         st.txData <= 8'hFF;
         st.txSt   <= USC_TX_IDLE;
      end else begin
         st <= next_st;
      end
   end
   // Outputs from flip-flops
   assign rdata         = st.rdata;
   assign busWait       = st.waitQ;
   assign receiveBuffer = st.rxBuf;
   assign rxBufValid    = st.rxFull;
   assign baseClockEn   = st.baseEn;
   assign txShiftData   = st.txData;
   assign txShiftLoad   = st.txLoad;

   // Error flags cleared one cycle after a read is served
   a_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
      st.rdPend && !(rxDoneValid && rxOn) |=> st.rxErr == 3'b000) else $error("read did not clear");
   a_rx_off_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !rxOn |=> st.rxErr == 3'b000) else $error("rx flags not cleared");
   a_tx_off_clear: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !txOn |=> !st.txBufFull && !st.txShiftBusy) else $error("tx flags not cleared");
   a_overrun_keep: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxOn && rxDoneValid && st.rxFull && !rxBufRead |=> st.rxErr[0] && $stable(st.rxBuf))
      else $error("overrun mishandled");
   a_framing_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxOn && rxDoneValid && !rxDone.firstStop |=> st.rxErr[1]) else $error("framing not set");
   a_zero_parity: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rxOn && rxDoneValid && parityMode == USC_PAR_ZERO && !st.rxErr[2] |=> !st.rxErr[2])
      else $error("zero parity flagged");
   sequence s_move;
      fifoOutValid && fifoOutReady && txOn;
   endsequence
   a_move_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      s_move |=> st.txShiftBusy && st.txLoad) else $error("move not flagged");
   a_write_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fifoPush |=> st.txBufFull) else $error("buffer flag not set");
   a_read_wait: assert property (@(posedge ref_clk) disable iff (!rst_n)
      errRead && !st.waitQ |=> busWait ##1 !busWait) else $error("wait not one cycle");
   a_high_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      rdata[7:4] == 4'h0) else $error("high bits not zero");
endmodule
